// file: include/vdo_pkg.sv
// vdo_pkg: constants shared by the display output stage
package vdo_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int VDO_AXI_AW = 5; // address bits decoded
	localparam logic [4:0] VDO_OFF_EVT = 5'h00; // field_event_counts
	localparam logic [4:0] VDO_OFF_CLIP = 5'h04; // output_clip_limits
	localparam logic [4:0] VDO_OFF_DEFV = 5'h08; // default_output_value
	localparam logic [4:0] VDO_OFF_CTRL = 5'h0C; // display_control_register
	localparam logic [4:0] VDO_OFF_STAT = 5'h10; // status, read only
	// ----------------------------------------------------------------
	// writable bits and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] VDO_EVT_MASK = 32'h0FFF0FFF;
	localparam logic [31:0] VDO_CLIP_RST = 32'hF010EB10;
	localparam logic [31:0] VDO_DEFV_YC_MASK = 32'hFFFF00FF;
	localparam logic [31:0] VDO_DEFV_RAW_MASK = 32'h000FFFFF;
	localparam logic [31:0] VDO_CTRL_MASK = 32'h0000001F;
	localparam logic [31:0] VDO_ZERO = 32'h00000000;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int VDO_CNT_W = 12; // event count width
	localparam int VDO_EVT1_LSB = 0;
	localparam int VDO_EVT2_LSB = 16;
	localparam int VDO_CH_LSB = 24; // chroma upper limit
	localparam int VDO_CL_LSB = 16; // chroma lower limit
	localparam int VDO_YH_LSB = 8; // luma upper limit
	localparam int VDO_YL_LSB = 0; // luma lower limit
	localparam int VDO_DCR_LSB = 24; // default red chroma
	localparam int VDO_DCB_LSB = 16; // default blue chroma
	localparam int VDO_DY_LSB = 0; // default luma
	localparam int VDO_RAW_W = 20; // raw word and bus width
	localparam int VDO_MODE_LSB = 0; // ctrl: mode, 2 bits
	localparam int VDO_WID_LSB = 2; // ctrl: bus width code, 2 bits
	localparam int VDO_BLK_BIT = 4; // ctrl: blanking_disable
	localparam int VDO_STAT_LVL_LSB = 16; // status: fifo level
	localparam int VDO_STAT_FLD_BIT = 31; // status: current field
	localparam logic [1:0] VDO_LSB_ZERO = 2'h0;
	// ----------------------------------------------------------------
	// modes, widths, bus answers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		VDO_MODE_BT656 = 2'h0,
		VDO_MODE_YC = 2'h1,
		VDO_MODE_RAW = 2'h2
	} vdo_mode_e;
	localparam logic [19:0] VDO_WMASK_8 = 20'h000FF;
	localparam logic [19:0] VDO_WMASK_10 = 20'h003FF;
	localparam logic [19:0] VDO_WMASK_16 = 20'h0FFFF;
	localparam logic [19:0] VDO_WMASK_20 = 20'hFFFFF;
	localparam logic [1:0] VDO_RESP_OKAY = 2'h0;
	localparam logic [1:0] VDO_RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int VDO_CLK_NS = 100; // sys_clk period
	localparam int VDO_EVT_GAP_NS = 400; // least spacing of request sets
	localparam int VDO_EVT_GAP_CYC = (VDO_EVT_GAP_NS + VDO_CLK_NS - 1)
		/ VDO_CLK_NS;
endpackage

// file: hw/vdo_out.sv
// vdo_out: display output stage with event counts, clip and default fill
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// vdo_fifo: pixel buffer, registered full/empty handshakes
// ----------------------------------------------------------------
module vdo_fifo #(
	parameter int W = 20,
	parameter int D = 16,
	parameter int LW = $clog2(D + 1)
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [LW-1:0] level
);
	logic [W-1:0] mem [D]; // storage
	logic [$clog2(D)-1:0] wp_reg; // write pointer
	logic [$clog2(D)-1:0] rp_reg; // read pointer
	logic push;
	logic pop;
	logic [LW-1:0] lvl_next;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rp_reg];
	assign lvl_next = level + LW'(push) - LW'(pop);

	// storage write and pointers
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wp_reg] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_reg <= '0;
			rp_reg <= '0;
			level <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else if (ce) begin
			if (push) begin
				wp_reg <= (wp_reg == ($clog2(D))'(D - 1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == ($clog2(D))'(D - 1)) ? '0 : rp_reg + 1'b1;
			end
			level <= lvl_next;
			in_ready <= lvl_next != LW'(D); // honest full
			out_valid <= lvl_next != '0; // honest empty
		end
	end
endmodule

// Summary of operation
// R1 - twelve-bit event count per field
// R2 - YC/656: each unit is three requests
// R3 - raw: each unit one luma request
// R4 - reserved bits read zero, ignore writes
// R5 - clip only in 656 and YC modes
// R6 - clip image area only, blanking unclipped
// R7 - chroma clamped between chroma limits
// R8 - luma clamped between luma limits
// R9 - clip limits reset to F0,10,EB,10
// R10 - compare upper eight bits, clamp clears two
// R11 - default where counters below image offsets
// R12 - 656 default in Cb Y Cr Y order
// R13 - YC default luma low, chroma high lane
// R14 - default byte high in lane, LSBs zero
// R15 - raw default trimmed to bus width
// R16 - raw default through all blanking
// R17 - blanking disable, empty FIFO: default across whole active area
// R18 - default register holds Cr, Cb, Y
// R19 - in-range samples pass unchanged
module vdo_out
	import vdo_pkg::*;
#(
	parameter int FIFO_D = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [vdo_pkg::VDO_AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [vdo_pkg::VDO_AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [vdo_pkg::VDO_RAW_W-1:0] pix_data,
	input wire logic pix_valid,
	output logic pix_ready,
	input wire logic field_start,
	input wire logic field_id,
	input wire logic active_video,
	input wire logic [11:0] image_line_counter,
	input wire logic [11:0] image_pixel_counter,
	input wire logic [11:0] image_vertical_offset,
	input wire logic [11:0] image_horizontal_offset,
	input wire logic [vdo_pkg::VDO_RAW_W-1:0] blank_code,
	output logic luma_dma_request,
	output logic blue_chroma_dma_request,
	output logic red_chroma_dma_request,
	output logic [vdo_pkg::VDO_RAW_W-1:0] display_output_bus
);
	import vdo_pkg::*;

	localparam int LW = $clog2(FIFO_D + 1);
	localparam logic [LW-1:0] HALF = LW'(FIFO_D / 2);

	typedef enum logic [1:0] {
		VDO_EV_IDLE = 2'b00,
		VDO_EV_RUN = 2'b01,
		VDO_EV_GAP = 2'b11
	} vdo_ev_e;

	logic [31:0] evt_reg; // field_event_counts
	logic [31:0] clip_reg; // output_clip_limits
	logic [31:0] defv_reg; // default_output_value
	logic [31:0] ctrl_reg; // display_control_register
	logic [VDO_AXI_AW-1:0] awaddr_reg; // held write address
	logic [31:0] wdata_reg; // held write data
	logic [3:0] wstrb_reg; // held strobes
	logic [VDO_AXI_AW-1:0] araddr_reg; // held read address
	logic wr_go; // both halves of a write present
	vdo_mode_e mode;
	logic [1:0] wid;
	logic blanking_disable;
	logic [31:0] defv_mask; // mode-dependent writable bits
	vdo_ev_e ev_reg; // request generator state
	logic [VDO_CNT_W-1:0] remain_reg; // request units left in field
	logic [2:0] gap_reg; // spacing countdown
	logic field_reg; // field being output
	logic f_valid;
	logic [VDO_RAW_W-1:0] f_data;
	logic [LW-1:0] f_level;
	logic [1:0] phase_reg; // Cb Y Cr Y position
	logic in_area;
	logic f_pop;
	logic show_def;
	logic [19:0] wmask;
	logic [VDO_RAW_W-1:0] out_next;
	logic def_q_reg; // output shows default
	logic img_q_reg; // output shows buffered image, clipped unless raw
	logic first_reg; // first cycle after reset

	assign mode = vdo_mode_e'(ctrl_reg[VDO_MODE_LSB +: 2]);
	assign wid = ctrl_reg[VDO_WID_LSB +: 2];
	assign blanking_disable = ctrl_reg[VDO_BLK_BIT];
	assign defv_mask = (mode == VDO_MODE_RAW) ? VDO_DEFV_RAW_MASK
		: VDO_DEFV_YC_MASK;

	// byte-lane merge, then drop reserved bits
	function automatic logic [31:0] vdo_wr(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] st, input logic [31:0] m);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				v[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		vdo_wr = v & m;
	endfunction

	// clamp a 10-bit sample on its upper eight bits
	function automatic logic [9:0] vdo_clip(input logic [9:0] s,
		input logic [7:0] hi, input logic [7:0] lo);
		if (s[9:2] > hi) begin
			vdo_clip = {hi, VDO_LSB_ZERO};
		end else if (s[9:2] < lo) begin
			vdo_clip = {lo, VDO_LSB_ZERO};
		end else begin
			vdo_clip = s;
		end
	endfunction

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// write channels: take address and data in any order
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= VDO_RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				case (awaddr_reg)
					VDO_OFF_EVT, VDO_OFF_CLIP, VDO_OFF_DEFV,
					VDO_OFF_CTRL, VDO_OFF_STAT: begin
						s_axi_bresp <= VDO_RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= VDO_RESP_SLVERR; // unmapped
					end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register storage; status is read only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_reg <= VDO_ZERO;
			clip_reg <= VDO_CLIP_RST; // see R9
			defv_reg <= VDO_ZERO;
			ctrl_reg <= VDO_ZERO;
		end else if (clk_en && wr_go) begin
			case (awaddr_reg)
				VDO_OFF_EVT: begin
					evt_reg <= vdo_wr(evt_reg, wdata_reg, wstrb_reg,
						VDO_EVT_MASK); // see R4
				end
				VDO_OFF_CLIP: begin
					clip_reg <= vdo_wr(clip_reg, wdata_reg, wstrb_reg,
						~VDO_ZERO);
				end
				VDO_OFF_DEFV: begin
					defv_reg <= vdo_wr(defv_reg, wdata_reg, wstrb_reg,
						defv_mask); // see R18
				end
				VDO_OFF_CTRL: begin
					ctrl_reg <= vdo_wr(ctrl_reg, wdata_reg, wstrb_reg,
						VDO_CTRL_MASK);
				end
				default: begin
				end
			endcase
		end
	end

	// read channel: one-cycle answer after the address is taken
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= VDO_ZERO;
			s_axi_rresp <= VDO_RESP_OKAY;
			araddr_reg <= '0;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= VDO_RESP_OKAY;
				araddr_reg <= s_axi_araddr;
				case (s_axi_araddr)
					VDO_OFF_EVT: s_axi_rdata <= evt_reg; // see R4
					VDO_OFF_CLIP: s_axi_rdata <= clip_reg;
					VDO_OFF_DEFV: s_axi_rdata <= defv_reg & defv_mask;
					VDO_OFF_CTRL: s_axi_rdata <= ctrl_reg;
					VDO_OFF_STAT: begin
						s_axi_rdata <= VDO_ZERO;
						s_axi_rdata[VDO_CNT_W-1:0] <= remain_reg;
						s_axi_rdata[VDO_STAT_LVL_LSB +: LW] <= f_level;
						s_axi_rdata[VDO_STAT_FLD_BIT] <= field_reg;
					end
					default: begin
						s_axi_rdata <= VDO_ZERO;
						s_axi_rresp <= VDO_RESP_SLVERR; // unmapped
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// request generator
	// ----------------------------------------------------------------
	// loads the field's count, issues one unit while the buffer is
	// under half full, then waits out the spacing gap
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ev_reg <= VDO_EV_IDLE;
			remain_reg <= '0;
			gap_reg <= '0;
			field_reg <= 1'b0;
			luma_dma_request <= 1'b0;
			blue_chroma_dma_request <= 1'b0;
			red_chroma_dma_request <= 1'b0;
		end else if (clk_en) begin
			luma_dma_request <= 1'b0;
			blue_chroma_dma_request <= 1'b0;
			red_chroma_dma_request <= 1'b0;
			if (field_start) begin
				field_reg <= field_id;
				remain_reg <= field_id ? evt_reg[VDO_EVT2_LSB +: VDO_CNT_W]
					: evt_reg[VDO_EVT1_LSB +: VDO_CNT_W]; // see R1
				ev_reg <= VDO_EV_RUN;
			end else begin
				case (ev_reg)
					VDO_EV_RUN: begin
						if (remain_reg == '0) begin
							ev_reg <= VDO_EV_IDLE;
						end else if (f_level < HALF) begin
							luma_dma_request <= 1'b1; // see R3
							blue_chroma_dma_request <= mode != VDO_MODE_RAW;
							red_chroma_dma_request <= mode != VDO_MODE_RAW;
							remain_reg <= remain_reg - 1'b1; // see R2
							gap_reg <= 3'(VDO_EVT_GAP_CYC - 1);
							ev_reg <= VDO_EV_GAP;
						end
					end
					VDO_EV_GAP: begin
						gap_reg <= gap_reg - 1'b1;
						if (gap_reg == '0) begin
							ev_reg <= VDO_EV_RUN;
						end
					end
					default: begin
						ev_reg <= VDO_EV_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// pixel buffer
	// ----------------------------------------------------------------
	vdo_fifo #(
		.W(VDO_RAW_W),
		.D(FIFO_D),
		.LW(LW)
	) u_fifo (
		.clk(sys_clk),
		.rst_b(rst_b),
		.ce(clk_en),
		.in_valid(pix_valid),
		.in_ready(pix_ready),
		.in_data(pix_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data),
		.level(f_level)
	);

	// ----------------------------------------------------------------
	// output datapath
	// ----------------------------------------------------------------
	always_comb begin
		in_area = active_video
			&& image_line_counter >= image_vertical_offset
			&& image_pixel_counter >= image_horizontal_offset; // see R11
		show_def = active_video && (!in_area
			|| (blanking_disable && !f_valid)); // see R17
		f_pop = clk_en && in_area && f_valid;
		case (wid) // see R15
			2'h0: wmask = VDO_WMASK_8;
			2'h1: wmask = VDO_WMASK_10;
			2'h2: wmask = VDO_WMASK_16;
			default: wmask = VDO_WMASK_20;
		endcase
	end

	// next bus value per mode and region
	always_comb begin
		out_next = display_output_bus; // underflow holds last value
		case (mode)
			VDO_MODE_RAW: begin
				if (!active_video || show_def) begin
					out_next = defv_reg[VDO_RAW_W-1:0] & wmask; // see R16
				end else if (f_valid) begin
					out_next = f_data & wmask; // see R5
				end
			end
			VDO_MODE_YC: begin
				if (!active_video) begin
					out_next = blank_code; // see R6
				end else if (show_def) begin
					out_next = {phase_reg[0] ? defv_reg[VDO_DCR_LSB +: 8]
						: defv_reg[VDO_DCB_LSB +: 8], VDO_LSB_ZERO,
						defv_reg[VDO_DY_LSB +: 8], VDO_LSB_ZERO}; // see R13
				end else if (f_valid) begin
					out_next = {vdo_clip(f_data[19:10],
						clip_reg[VDO_CH_LSB +: 8], clip_reg[VDO_CL_LSB +: 8]),
						vdo_clip(f_data[9:0], clip_reg[VDO_YH_LSB +: 8],
						clip_reg[VDO_YL_LSB +: 8])}; // see R7
				end
			end
			default: begin
				if (!active_video) begin
					out_next = blank_code;
				end else if (show_def) begin
					out_next = '0;
					case (phase_reg) // see R12
						2'h0: out_next[9:0] = {defv_reg[VDO_DCB_LSB +: 8],
							VDO_LSB_ZERO}; // see R14
						2'h2: out_next[9:0] = {defv_reg[VDO_DCR_LSB +: 8],
							VDO_LSB_ZERO};
						default: out_next[9:0] = {defv_reg[VDO_DY_LSB +: 8],
							VDO_LSB_ZERO};
					endcase
				end else if (f_valid) begin
					out_next = '0;
					out_next[9:0] = phase_reg[0]
						? vdo_clip(f_data[9:0], clip_reg[VDO_YH_LSB +: 8],
						clip_reg[VDO_YL_LSB +: 8]) // see R8
						: vdo_clip(f_data[9:0], clip_reg[VDO_CH_LSB +: 8],
						clip_reg[VDO_CL_LSB +: 8]); // see R10
				end
			end
		endcase
	end

	// output register, sample phase and region flags
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			display_output_bus <= '0;
			phase_reg <= '0;
			def_q_reg <= 1'b0;
			img_q_reg <= 1'b0;
			first_reg <= 1'b1;
		end else if (clk_en) begin
			first_reg <= 1'b0;
			display_output_bus <= out_next; // see R19
			phase_reg <= active_video ? phase_reg + 1'b1 : '0;
			def_q_reg <= show_def;
			img_q_reg <= active_video && !show_def && f_valid;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	AST_EVT_RSVD: assert property ( // see R4
		s_axi_rvalid && araddr_reg == VDO_OFF_EVT
		|-> (s_axi_rdata & ~VDO_EVT_MASK) == VDO_ZERO)
		else $error("reserved event bits read nonzero");
	AST_CLIP_RST: assert property ( // see R9
		first_reg |-> clip_reg == VDO_CLIP_RST)
		else $error("clip limits wrong after reset");
	AST_RAW_ONE: assert property ( // see R3
		luma_dma_request && $past(mode) == VDO_MODE_RAW
		|-> !blue_chroma_dma_request && !red_chroma_dma_request)
		else $error("chroma request in raw mode");
	AST_SET_THREE: assert property ( // see R2
		luma_dma_request && $past(mode) != VDO_MODE_RAW
		|-> blue_chroma_dma_request && red_chroma_dma_request)
		else $error("incomplete request set");
	AST_COUNT_LOAD: assert property ( // see R1
		clk_en && field_start && !field_id
		|=> remain_reg == $past(evt_reg[VDO_EVT1_LSB +: VDO_CNT_W]))
		else $error("field count not loaded");
	AST_YC_LANES: assert property ( // see R14
		def_q_reg && mode == VDO_MODE_YC && $stable(mode)
		|-> display_output_bus[1:0] == VDO_LSB_ZERO
		&& display_output_bus[11:10] == VDO_LSB_ZERO)
		else $error("default lane LSBs not zero");
	AST_LUMA_CLIP: assert property ( // see R8
		img_q_reg && mode == VDO_MODE_BT656 && $stable(clip_reg)
		&& $stable(mode) && $past(phase_reg[0])
		|-> display_output_bus[9:2] <= clip_reg[VDO_YH_LSB +: 8]
		&& display_output_bus[9:2] >= clip_reg[VDO_YL_LSB +: 8])
		else $error("luma outside limits");
	AST_RAW_BLANK: assert property ( // see R16
		clk_en && mode == VDO_MODE_RAW && !active_video
		|=> display_output_bus
		== ($past(defv_reg[VDO_RAW_W-1:0]) & $past(wmask)))
		else $error("raw blanking not default");
	AST_BLK_DEF: assert property ( // see R17
		clk_en && active_video && blanking_disable && !f_valid
		|=> def_q_reg)
		else $error("empty buffer not filled with default");
endmodule

`default_nettype wire

// file: verif/vdo_disp_model.sv
// vdo_disp_model: display device that samples the output bus
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// sink: latches the bus mid-cycle, where it is settled
// ----------------------------------------------------------------
module vdo_disp_model (
	input wire logic sys_clk,
	input wire logic [19:0] bus,
	output logic [19:0] seen
);
	// capture on the falling edge, away from the launch edge
	always_ff @(negedge sys_clk) begin
		seen <= bus;
	end
endmodule
`default_nettype wire

// file: verif/vdo_out_tb.sv
// vdo_out_tb: self-checking bench for the display output stage
`timescale 1ns/1ps
`default_nettype none
module vdo_out_tb;
	import vdo_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic sys_clk = '0, rst_b = '0;
	logic [4:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rdat, q;
	logic awv = '0, wv = '0, br = '0, arv = '0, rr = '0;
	logic awrdy, wrdy, bv, arrdy, rv, prdy, lreq, breq, rreq;
	logic [1:0] bresp, rresp, r;
	logic [19:0] pd = '0, bc = '0, dob, seen, v;
	logic pv = '0, fs = '0, fid = '0, act = '0, ce = '1;
	logic [11:0] ilc = '0, ipc = '0, ivo = 12'h4, iho = 12'h2;
	logic [19:0] pq[$]; // pixels pushed, in order
	logic [19:0] wm[4] = '{VDO_WMASK_8, VDO_WMASK_10, VDO_WMASK_16,
		VDO_WMASK_20};
	int mismatches = 0, check_count = 0, nl = 0, nb = 0, nr = 0;
	int seed = 32'h7FA5;
	// ----------------------------------------------------------------
	// design, display model, clock
	// ----------------------------------------------------------------
	vdo_out #(.FIFO_D(16)) i_vdo_out (
		.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(ce),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arrdy), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .pix_data(pd),
		.pix_valid(pv), .pix_ready(prdy), .field_start(fs),
		.field_id(fid), .active_video(act), .image_line_counter(ilc),
		.image_pixel_counter(ipc), .image_vertical_offset(ivo),
		.image_horizontal_offset(iho), .blank_code(bc),
		.luma_dma_request(lreq), .blue_chroma_dma_request(breq),
		.red_chroma_dma_request(rreq), .display_output_bus(dob));
	vdo_disp_model i_vdo_disp_model (.sys_clk(sys_clk), .bus(dob),
		.seen(seen));
	always #50 sys_clk = ~sys_clk;
	// request pulses counted mid-cycle
	always @(negedge sys_clk) begin
		nl += lreq;
		nb += breq;
		nr += rreq;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one AXI4-Lite transfer; ready and answer judged before the edge
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		logic ta, tw, td;
		n = 0;
		td = 0;
		if (w) begin
			awa <= a;
			wd <= d;
			awv <= 1;
			wv <= 1;
			br <= 1;
		end else begin
			ara <= a;
			arv <= 1;
			rr <= 1;
		end
		while (!td && n < 50) begin
			@(negedge sys_clk);
			ta = w ? (awv & awrdy) : (arv & arrdy);
			tw = wv & wrdy;
			td = w ? bv : rv;
			q = rdat;
			r = w ? bresp : rresp;
			@(posedge sys_clk);
			if (ta) begin
				awv <= 0;
				arv <= 0;
			end
			if (tw) wv <= 0;
			if (td) begin
				br <= 0;
				rr <= 0;
			end
			n++;
		end
		@(posedge sys_clk); // idle edge between transfers
		if (!td) mismatches++;
	endtask
	task automatic wrr(input logic [4:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask
	task automatic rdd(input logic [4:0] a);
		xfer(0, a, 32'h0);
	endtask
	// hold one pixel offered until the buffer takes it
	task automatic push(input logic [19:0] d);
		int n;
		logic t;
		n = 0;
		t = 0;
		pv <= 1;
		pd <= d;
		pq.push_back(d);
		while (!t && n < 50) begin
			@(negedge sys_clk);
			t = prdy;
			@(posedge sys_clk);
			n++;
		end
		if (!t) mismatches++;
	endtask
	// compare what the display saw this cycle
	task automatic obs(input logic [19:0] m, input logic [19:0] e);
		@(negedge sys_clk);
		#1 chk({12'h0, seen & m}, {12'h0, e});
		@(posedge sys_clk);
	endtask
	// field start pulse, then time for every request set
	task automatic fld(input logic f);
		nl = 0;
		nb = 0;
		nr = 0;
		fid <= f;
		fs <= 1;
		@(posedge sys_clk);
		fs <= 0;
		repeat (60) @(posedge sys_clk);
	endtask
	// expected clamp of one 10-bit sample
	function automatic logic [9:0] clp(input logic [9:0] s,
		input logic [7:0] hi, input logic [7:0] lo);
		if (s[9:2] > hi) return {hi, 2'h0};
		if (s[9:2] < lo) return {lo, 2'h0};
		return s;
	endfunction
	// expected Y/C word: chroma high lane, luma low lane
	function automatic logic [19:0] yc(input logic [19:0] s,
		input logic [31:0] c);
		return {clp(s[19:10], c[31:24], c[23:16]),
			clp(s[9:0], c[15:8], c[7:0])};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		#500000;
		mismatches++;
		summarize();
	end
	initial begin
		bc <= 20'($random(seed));
		repeat (2) @(posedge sys_clk);
		rst_b <= 1;
		@(posedge sys_clk);
		rdd(VDO_OFF_CLIP);
		chk(q, VDO_CLIP_RST);
		wrr(VDO_OFF_EVT, 32'hFFFFFFFF);
		rdd(VDO_OFF_EVT);
		chk(q, 32'h0FFF0FFF);
		wrr(VDO_OFF_DEFV, 32'hFFFFFFFF);
		rdd(VDO_OFF_DEFV);
		chk(q, 32'hFFFF00FF);
		rdd(5'h14);
		chk(32'(r), 32'(VDO_RESP_SLVERR));
		wrr(5'h14, 32'h1);
		chk(32'(r), 32'(VDO_RESP_SLVERR));
		wrr(VDO_OFF_DEFV, 32'hC25A003D);
		obs(VDO_WMASK_20, bc);
		act <= 1;
		@(posedge sys_clk);
		obs(VDO_WMASK_10, 20'h168);
		ce <= 0;
		obs(VDO_WMASK_10, 20'h0F4);
		obs(VDO_WMASK_10, 20'h0F4); // frozen: bus and phase hold
		ce <= 1;
		obs(VDO_WMASK_10, 20'h0F4);
		obs(VDO_WMASK_10, 20'h308);
		obs(VDO_WMASK_10, 20'h0F4);
		act <= 0;
		ilc <= 12'h5;
		wrr(VDO_OFF_CTRL, 32'h1);
		act <= 1;
		@(posedge sys_clk);
		obs(VDO_WMASK_20, 20'h5A0F4);
		obs(VDO_WMASK_20, 20'hC20F4);
		act <= 0;
		ipc <= 12'h9;
		wrr(VDO_OFF_CLIP, 32'hC040D020);
		for (int i = 0; i < 16; i++) push(20'($random(seed)));
		pv <= 0;
		@(negedge sys_clk);
		chk(32'(prdy), 32'h0);
		obs(VDO_WMASK_20, bc);
		act <= 1;
		@(posedge sys_clk);
		foreach (pq[i])
			obs(VDO_WMASK_20, yc(pq[i], 32'hC040D020));
		act <= 0;
		wrr(VDO_OFF_CTRL, 32'h11);
		act <= 1;
		@(posedge sys_clk);
		obs(VDO_WMASK_20, 20'h5A0F4);
		obs(VDO_WMASK_20, 20'hC20F4);
		act <= 0;
		wrr(VDO_OFF_CTRL, 32'h2);
		wrr(VDO_OFF_DEFV, 32'hFFFFFFFF);
		rdd(VDO_OFF_DEFV);
		chk(q, 32'h000FFFFF);
		v = 20'($random(seed));
		wrr(VDO_OFF_DEFV, {12'h0, v});
		for (int w = 0; w < 4; w++) begin
			wrr(VDO_OFF_CTRL, 32'(w * 4 + 2));
			obs(wm[w], v & wm[w]);
		end
		push(20'hFFFFF);
		pv <= 0;
		act <= 1;
		@(posedge sys_clk);
		obs(VDO_WMASK_20, 20'hFFFFF);
		act <= 0;
		// 656 image: chroma limits on even phases, luma on odd
		wrr(VDO_OFF_CTRL, 32'h0);
		pq.delete();
		push(20'h003FF);
		push(20'h00000);
		for (int i = 0; i < 6; i++) push(20'($random(seed)));
		pv <= 0;
		act <= 1;
		@(posedge sys_clk);
		foreach (pq[i]) begin
			v = {10'h0, (i & 1) ? clp(pq[i][9:0], 8'hD0, 8'h20)
				: clp(pq[i][9:0], 8'hC0, 8'h40)};
			obs(VDO_WMASK_20, v);
		end
		act <= 0;
		wrr(VDO_OFF_EVT, 32'h00020003);
		wrr(VDO_OFF_CTRL, 32'h1);
		fld(0);
		chk(nl, 3);
		chk(nb, 3);
		chk(nr, 3);
		wrr(VDO_OFF_CTRL, 32'h2);
		fld(1);
		chk(nl, 2);
		chk(nb + nr, 0);
		summarize();
	end
endmodule
`default_nettype wire
